/* hdl/npc_defines.svh */
// constants for the memory program controller: offsets, fields, codes, timing
// assumes inclusion by bare name from the design file and the bench files
`ifndef NPC_DEFINES_SVH
`define NPC_DEFINES_SVH
`define NPC_IO_CMD_ADDR 6'h33
`define NPC_IO_CSR_ADDR 6'h32
`define NPC_CMD_RESET 8'h00
`define NPC_CSR_BUSY_BIT 7
`define NPC_CMD_NOP 6'h00
`define NPC_CMD_CHIP_ERASE 6'h10
`define NPC_CMD_SECTION_ERASE 6'h14
`define NPC_CMD_PAIR_WRITE 6'h1D
`define NPC_SEL_LOCK 4'h3
`define NPC_LOCK_WORD 15'h1F80
`define NPC_SEL_CONFIG 4'h4
`define NPC_SEL_CALIB 4'h5
`define NPC_SEL_SIGNATURE 4'h6
`define NPC_SEL_CODE_LO 4'h8
`define NPC_SEL_CODE_HI 4'hF
`define NPC_WORD_TOP_BIT 4
`define NPC_PAGE_TOP_BIT 10
`define NPC_ERASED_BYTE 8'hFF
`define NPC_ERASE_TIME_US 100
`define NPC_WRITE_TIME_US 50
`define NPC_CLOCK_MHZ 50
`endif

/* hdl/npc_pkg.sv */
// types for the memory program controller
// assumes npc_defines.svh is on the include path
package npc_pkg;
  typedef enum logic [2:0] {NPC_IDLE, NPC_ERASE_CODE, NPC_CLEAR_LOCK, NPC_ERASE_CONFIG, NPC_WRITE_PAIR} npc_state_t;
  typedef enum logic [1:0] {NPC_TGT_NONE, NPC_TGT_LOCK, NPC_TGT_CONFIG, NPC_TGT_CODE} npc_target_t;
  typedef struct packed {
    logic write;
    logic read;
    logic [15:0] addr;
    logic [7:0] data;
  } npc_data_req_t;
  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] addr;
    logic [7:0] data;
  } npc_io_req_t;
endpackage

/* hdl/nvm_program_controller.sv */
// memory program controller: command and status registers, mapped code, config and lock storage
// assumes the link front end hands over one byte access per cycle with internal or external origin
`include "npc_defines.svh"

// Function
// - load a command, then a data-space byte write starts the operation
// - busy flag held throughout any erase or programming operation
// - command register writes ignored while busy
// - while programming, other programming suppressed and reads return invalid
// - writes or erases from the internal processor are refused
// - upper address bits pick lock or section; bits 4:1 word, above page
// - code section 2048 bytes, 64 pages of 16 words
// - byte reads; address bit 0 low selects low byte, high selects high byte
// - two words written per operation, low byte before high byte
// - erase only whole sections
// - chip erase clears code then lock; config, signature, calibration untouched
// - chip erase started by dummy write to a code word high byte
// - no buffer loading and no flash reads during erase
// - section erase of code started by dummy code-word high byte write
// - section erase of config started by dummy config high byte write
// - lock byte readable; written by pair command, low byte then dummy high
// - command register bits 7:6 read zero
// - programmer reaches control registers in io space, memory in data space
// - command codes 00 nop, 10 chip erase, 14 section erase, 1D pair write
// - status bit 7 is busy, other bits read zero
module npc_nvm_program_controller
  import npc_pkg::*;
#(
  parameter int CODE_BYTES = 2048,
  parameter int CONFIG_BYTES = 16,
  parameter int CALIB_BYTES = 16,
  parameter int SIG_BYTES = 32,
  parameter int ERASE_CYCLES = `NPC_ERASE_TIME_US * `NPC_CLOCK_MHZ,
  parameter int WRITE_CYCLES = `NPC_WRITE_TIME_US * `NPC_CLOCK_MHZ
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic programmingEnabled,
  input wire logic externalOrigin,
  input wire npc_io_req_t ioReq,
  input wire npc_data_req_t dataReq,
  output logic [7:0] ioReadData,
  output logic [7:0] dataReadData,
  output logic dataReadValid,
  output logic memoryBusyFlag
);
  localparam int CW = $clog2(CODE_BYTES);
  localparam int FW = $clog2(CONFIG_BYTES);
  localparam int CNT_W = $clog2(ERASE_CYCLES + WRITE_CYCLES + 2);

  logic [7:0] codeMem [CODE_BYTES];
  logic [7:0] configMem [CONFIG_BYTES];
  logic [7:0] calibMem [CALIB_BYTES];
  logic [7:0] sigMem [SIG_BYTES];
  logic [7:0] lockByte;
  logic [5:0] memoryCommand;
  npc_state_t state;
  logic [CNT_W-1:0] timer;
  logic [7:0] pairBuf [4];
  logic [1:0] pairCount;
  logic [15:0] pairAddr;
  npc_target_t pairTarget;
  npc_target_t target;
  logic [3:0] sel;
  logic dataWrite;
  logic startOp;
  logic busy;
  logic timerDone;
  logic pairLoad;
  logic loadErase;
  logic loadWrite;
  logic [7:0] readByte;
  npc_state_t next_state;

  // section decode on the upper nibble
  assign sel = dataReq.addr[15:12];
  always_comb
  begin
    if (sel >= `NPC_SEL_CODE_LO && sel <= `NPC_SEL_CODE_HI && dataReq.addr[11:CW] == '0)
      target = NPC_TGT_CODE;
    else if (sel == `NPC_SEL_CONFIG && dataReq.addr[11:FW] == '0)
      target = NPC_TGT_CONFIG;
    else if (sel == `NPC_SEL_LOCK && dataReq.addr[15:1] == `NPC_LOCK_WORD)
      target = NPC_TGT_LOCK;
    else
      target = NPC_TGT_NONE;
  end

  assign busy = (state != NPC_IDLE);
  assign timerDone = (timer == '0);
  // internal stores never reach the array; link must be enabled too
  assign dataWrite = dataReq.write && externalOrigin && programmingEnabled && !busy;
  // only a high-byte write can start erases; nop starts nothing
  assign startOp = dataWrite && dataReq.addr[0] && target != NPC_TGT_NONE;
  assign pairLoad = dataWrite && memoryCommand == `NPC_CMD_PAIR_WRITE && target != NPC_TGT_NONE;

  // command register
  always_ff @(posedge clock)
  begin
    if (!nrst)
      memoryCommand <= `NPC_CMD_NOP;
    else if (ioReq.write && externalOrigin && ioReq.addr == `NPC_IO_CMD_ADDR && !busy)
      memoryCommand <= ioReq.data[5:0];
  end

  // io reads of command and status
  always_ff @(posedge clock)
  begin
    if (!nrst)
      ioReadData <= 8'h00;
    else if (ioReq.read && ioReq.addr == `NPC_IO_CMD_ADDR)
      ioReadData <= {2'b00, memoryCommand};
    else if (ioReq.read && ioReq.addr == `NPC_IO_CSR_ADDR)
      ioReadData <= {busy, 7'h00};
    else if (ioReq.read)
      ioReadData <= 8'h00;
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      memoryBusyFlag <= 1'b0;
    else
      memoryBusyFlag <= busy;
  end

  // pair buffer: low then high of first word, then of second
  always_ff @(posedge clock)
  begin
    if (!nrst)
      pairCount <= 2'd0;
    else if (pairLoad)
    begin
      // lock word is a single word: its high byte completes the pair
      if (target == NPC_TGT_LOCK && dataReq.addr[0])
        pairCount <= 2'd0;
      else
        pairCount <= pairCount + 2'd1;
    end
    else if (busy)
      pairCount <= 2'd0;
  end

  // base is the first byte rounded to four; a misaligned start stores bytes from the base in arrival order
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pairAddr <= 16'h0000;
      pairTarget <= NPC_TGT_NONE;
    end
    else if (pairLoad && pairCount == 2'd0)
    begin
      pairAddr <= {dataReq.addr[15:2], 2'b00};
      pairTarget <= target;
    end
  end

  // slot data needs no reset: a slot is always loaded before it is used
  always_ff @(posedge clock)
  begin
    if (pairLoad)
      pairBuf[pairCount] <= dataReq.data;
  end

  // operation sequencer: one start per idle cycle
  always_comb
  begin
    next_state = state;
    loadErase = 1'b0;
    loadWrite = 1'b0;
    case (state)
      NPC_IDLE:
      begin
        if (startOp && memoryCommand == `NPC_CMD_CHIP_ERASE && target == NPC_TGT_CODE)
        begin
          next_state = NPC_ERASE_CODE;
          loadErase = 1'b1;
        end
        else if (startOp && memoryCommand == `NPC_CMD_SECTION_ERASE && target == NPC_TGT_CODE)
        begin
          next_state = NPC_ERASE_CODE;
          loadErase = 1'b1;
        end
        else if (startOp && memoryCommand == `NPC_CMD_SECTION_ERASE && target == NPC_TGT_CONFIG)
        begin
          next_state = NPC_ERASE_CONFIG;
          loadErase = 1'b1;
        end
        else if (startOp && memoryCommand == `NPC_CMD_PAIR_WRITE &&
                 (pairCount == 2'd3 || (target == NPC_TGT_LOCK && pairCount == 2'd1)))
        begin
          next_state = NPC_WRITE_PAIR;
          loadWrite = 1'b1;
        end
      end
      NPC_ERASE_CODE:
      begin
        // lock cleared only once code is fully erased
        if (timerDone && memoryCommand == `NPC_CMD_CHIP_ERASE)
          next_state = NPC_CLEAR_LOCK;
        else if (timerDone)
          next_state = NPC_IDLE;
      end
      NPC_CLEAR_LOCK:
        next_state = NPC_IDLE;
      NPC_ERASE_CONFIG, NPC_WRITE_PAIR:
      begin
        if (timerDone)
          next_state = NPC_IDLE;
      end
      default:
        next_state = NPC_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      state <= NPC_IDLE;
    else
      state <= next_state;
  end

  // one shared length counter: only one operation can run at a time
  always_ff @(posedge clock)
  begin
    if (!nrst)
      timer <= '0;
    else if (loadErase)
      timer <= CNT_W'(ERASE_CYCLES - 1);
    else if (loadWrite)
      timer <= CNT_W'(WRITE_CYCLES - 1);
    else if (busy && !timerDone)
      timer <= timer - CNT_W'(1);
  end

  // code array updates at operation end; erase clears the whole section, pair write four bytes
  always_ff @(posedge clock)
  begin
    if (state == NPC_ERASE_CODE && timerDone)
    begin
      for (int i = 0; i < CODE_BYTES; i++)
        codeMem[i] <= `NPC_ERASED_BYTE;
    end
    else if (state == NPC_WRITE_PAIR && timerDone && pairTarget == NPC_TGT_CODE)
    begin
      // programming only clears bits, so an unerased word mixes contents
      for (int k = 0; k < 4; k++)
        codeMem[pairAddr[CW-1:0] + CW'(k)] <= codeMem[pairAddr[CW-1:0] + CW'(k)] & pairBuf[k];
    end
  end

  // config array likewise
  always_ff @(posedge clock)
  begin
    if (state == NPC_ERASE_CONFIG && timerDone)
    begin
      for (int i = 0; i < CONFIG_BYTES; i++)
        configMem[i] <= `NPC_ERASED_BYTE;
    end
    else if (state == NPC_WRITE_PAIR && timerDone && pairTarget == NPC_TGT_CONFIG)
    begin
      for (int k = 0; k < 4; k++)
        configMem[pairAddr[FW-1:0] + FW'(k)] <= configMem[pairAddr[FW-1:0] + FW'(k)] & pairBuf[k];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
      lockByte <= `NPC_ERASED_BYTE;
    else if (state == NPC_CLEAR_LOCK)
      lockByte <= `NPC_ERASED_BYTE;
    else if (state == NPC_WRITE_PAIR && timerDone && pairTarget == NPC_TGT_LOCK)
      lockByte <= lockByte & pairBuf[0];
  end

  // byte select; unmapped locations read zero
  always_comb
  begin
    readByte = 8'h00;
    case (target)
      NPC_TGT_CODE:
        readByte = codeMem[dataReq.addr[CW-1:0]];
      NPC_TGT_CONFIG:
        readByte = configMem[dataReq.addr[FW-1:0]];
      NPC_TGT_LOCK:
        readByte = dataReq.addr[0] ? 8'h00 : lockByte;
      default:
      begin
        if (sel == `NPC_SEL_CALIB)
          readByte = calibMem[dataReq.addr[$clog2(CALIB_BYTES)-1:0]];
        else if (sel == `NPC_SEL_SIGNATURE)
          readByte = sigMem[dataReq.addr[$clog2(SIG_BYTES)-1:0]];
      end
    endcase
  end

  // byte reads; invalid while any operation runs
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      dataReadData <= 8'h00;
      dataReadValid <= 1'b0;
    end
    else if (dataReq.read && !busy)
    begin
      dataReadValid <= 1'b1;
      dataReadData <= readByte;
    end
    else
    begin
      dataReadValid <= 1'b0;
      dataReadData <= 8'h00;
    end
  end

  // read-only sections hold arbitrary neutral content
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < CALIB_BYTES; i++)
        calibMem[i] <= `NPC_ERASED_BYTE;
      for (int i = 0; i < SIG_BYTES; i++)
        sigMem[i] <= `NPC_ERASED_BYTE;
    end
  end
endmodule

/* bench/npc_checker_asserts.sv */
// port assertions for the program controller
// assumes a bind into npc_nvm_program_controller
`include "npc_defines.svh"
module npc_checker_asserts
  import npc_pkg::*;
#(
  parameter int ERASE_CYCLES = 4,
  parameter int WRITE_CYCLES = 3
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic programmingEnabled,
  input wire logic externalOrigin,
  input wire npc_io_req_t ioReq,
  input wire npc_data_req_t dataReq,
  input wire logic [7:0] ioReadData,
  input wire logic [7:0] dataReadData,
  input wire logic dataReadValid,
  input wire logic memoryBusyFlag
);
  // bound kept small: long default counts exceed a delay range
  localparam int maxBusy = ERASE_CYCLES + WRITE_CYCLES + 2;
  logic startOk;
  logic rdReq;
  logic csrRd;
  logic cmdRd;
  assign startOk = dataReq.write & externalOrigin & programmingEnabled;
  assign rdReq = dataReq.read;
  assign csrRd = ioReq.read && ioReq.addr == `NPC_IO_CSR_ADDR;
  assign cmdRd = ioReq.read && ioReq.addr == `NPC_IO_CMD_ADDR;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);
  chk_busy_cause: assert property ($rose(memoryBusyFlag) |-> $past(startOk, 2))
    else $error("busy rose without a write");
  chk_busy_holds: assert property ($rose(memoryBusyFlag) |-> memoryBusyFlag[*3])
    else $error("busy dropped early");
  chk_busy_ends: assert property ($rose(memoryBusyFlag) |-> ##[1:maxBusy] !memoryBusyFlag)
    else $error("busy stuck");
  chk_read_blocked: assert property ((rdReq && memoryBusyFlag) ##1 memoryBusyFlag |-> !dataReadValid)
    else $error("read valid while busy");
  chk_valid_cause: assert property (dataReadValid |-> $past(rdReq))
    else $error("valid without read");
  chk_invalid_zero: assert property (!dataReadValid |-> dataReadData == 8'h00)
    else $error("data without valid");
  chk_cmd_reserved: assert property (cmdRd |=> ioReadData[7:6] == 2'h0)
    else $error("command top bits set");
  chk_csr_zero: assert property (csrRd |=> ioReadData[6:0] == 7'h00)
    else $error("status low bits set");
  chk_csr_busy: assert property (csrRd |=> ioReadData[7] == memoryBusyFlag)
    else $error("status busy mismatch");
  cover property ($rose(memoryBusyFlag));
  cover property (dataReadValid);
  cover property (rdReq && memoryBusyFlag);
endmodule

bind npc_nvm_program_controller npc_checker_asserts #(.ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
  u_npc_checker_asserts (.clock(clock), .nrst(nrst), .programmingEnabled(programmingEnabled),
  .externalOrigin(externalOrigin), .ioReq(ioReq), .dataReq(dataReq), .ioReadData(ioReadData),
  .dataReadData(dataReadData), .dataReadValid(dataReadValid), .memoryBusyFlag(memoryBusyFlag));

/* bench/npc_pgm.sv */
// external programmer model: io and data byte accesses
// assumes one caller at a time
`include "npc_defines.svh"
module npc_pgm
  import npc_pkg::*;
(
  input wire logic clock,
  input wire logic [7:0] ioReadData,
  input wire logic [7:0] dataReadData,
  input wire logic dataReadValid,
  output npc_io_req_t ioReq,
  output npc_data_req_t dataReq,
  output logic externalOrigin,
  output logic programmingEnabled
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    ioReq = '0;
    dataReq = '0;
    externalOrigin = 1'b1;
    programmingEnabled = 1'b0;
  end
  // released lines show inverted values, never stale ones
  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    ioReq <= '{w, !w, a, d};
    @(posedge clock);
    ioReq <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = ioReadData;
  endtask
  task automatic mem(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q, output logic v);
    @(posedge clock);
    dataReq <= '{w, !w, a, d};
    @(posedge clock);
    dataReq <= '{1'b0, 1'b0, ~a, ~d};
    #1;
    q = dataReadData;
    v = dataReadValid;
  endtask
  task automatic set(input logic e, input logic o);
    @(posedge clock);
    programmingEnabled <= e;
    externalOrigin <= o;
  endtask
  task automatic cmd(input logic [5:0] c);
    logic [7:0] q;
    io(1'b1, `NPC_IO_CMD_ADDR, {2'h0, c}, q);
  endtask
  task automatic pairWr(input logic [15:0] a, input logic [31:0] w);
    logic [7:0] q;
    logic v;
    cmd(`NPC_CMD_PAIR_WRITE);
    mem(1'b1, a, w[7:0], q, v);
    mem(1'b1, a + 16'h0001, w[15:8], q, v);
    if (a[15:8] != 8'h3F)
    begin
      @(posedge clock); // idle character
      mem(1'b1, a + 16'h0002, w[23:16], q, v);
      mem(1'b1, a + 16'h0003, w[31:24], q, v);
    end
  endtask
  task automatic erase(input logic [5:0] c, input logic [15:0] a);
    logic [7:0] q;
    logic v;
    cmd(c);
    mem(1'b1, a, 8'h00, q, v);
  endtask
  task automatic waitIdle(output int n);
    logic [7:0] s;
    n = 0;
    s = 8'h80;
    while (s[7] !== 1'b0 && n < 20)
    begin
      io(1'b0, `NPC_IO_CSR_ADDR, 8'h00, s);
      n++;
    end
  endtask
endmodule

/* bench/tb_top.sv */
// bench: programmer model drives the controller, tasks judge replies
// assumes short erase and write counts set below
`include "npc_defines.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top
  import npc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  npc_io_req_t ioReq;
  npc_data_req_t dataReq;
  logic externalOrigin;
  logic programmingEnabled;
  logic [7:0] ioReadData;
  logic [7:0] dataReadData;
  logic dataReadValid;
  logic memoryBusyFlag;
  logic [7:0] q;
  logic v;
  int n;
  int num_errors = 0;
  int n_compared = 0;
  always #10 clock = ~clock;
  npc_nvm_program_controller #(.ERASE_CYCLES(4), .WRITE_CYCLES(3)) u_npc_nvm_program_controller (.clock(clock),
    .nrst(nrst), .programmingEnabled(programmingEnabled), .externalOrigin(externalOrigin), .ioReq(ioReq),
    .dataReq(dataReq), .ioReadData(ioReadData), .dataReadData(dataReadData), .dataReadValid(dataReadValid),
    .memoryBusyFlag(memoryBusyFlag));
  npc_pgm u_npc_pgm (.clock(clock), .ioReadData(ioReadData), .dataReadData(dataReadData),
    .dataReadValid(dataReadValid), .ioReq(ioReq), .dataReq(dataReq), .externalOrigin(externalOrigin),
    .programmingEnabled(programmingEnabled));
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    u_npc_pgm.mem(1'b0, a, 8'h00, q, v);
    `CHK({v, q}, {1'b1, e})
  endtask
  task automatic noStart();
    repeat (3) @(posedge clock);
    #1;
    `CHK(memoryBusyFlag, 1'b0)
  endtask
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic t_write();
    u_npc_pgm.io(1'b0, `NPC_IO_CMD_ADDR, 8'h00, q);
    `CHK(q, 8'h00)
    rd(16'h3F00, 8'hFF);
    u_npc_pgm.set(1'b1, 1'b1);
    u_npc_pgm.erase(`NPC_CMD_SECTION_ERASE, 16'h8001);
    u_npc_pgm.waitIdle(n);
    `CHK(n > 1 && n < 20, 1'b1)
    rd(16'h8004, 8'hFF);
    u_npc_pgm.pairWr(16'h8004, 32'h44332211);
    u_npc_pgm.mem(1'b0, 16'h8004, 8'h00, q, v);
    `CHK({v, q}, 9'h000)
    u_npc_pgm.waitIdle(n);
    for (int i = 0; i < 4; i++)
      rd(16'h8004 + 16'(i), 8'h11 * 8'(i + 1));
    $display("t_write done");
  endtask
  task automatic t_chip();
    u_npc_pgm.erase(`NPC_CMD_SECTION_ERASE, 16'h4001);
    u_npc_pgm.waitIdle(n);
    u_npc_pgm.pairWr(16'h4000, 32'hFFFFA55A);
    u_npc_pgm.waitIdle(n);
    u_npc_pgm.pairWr(16'h3F00, 32'h000000F0);
    u_npc_pgm.waitIdle(n);
    rd(16'h3F00, 8'hF0);
    u_npc_pgm.erase(`NPC_CMD_CHIP_ERASE, 16'h8003);
    u_npc_pgm.cmd(`NPC_CMD_SECTION_ERASE); // refused while busy
    u_npc_pgm.io(1'b0, `NPC_IO_CMD_ADDR, 8'h00, q);
    `CHK(q, {2'h0, `NPC_CMD_CHIP_ERASE})
    u_npc_pgm.waitIdle(n);
    rd(16'h8006, 8'hFF);
    rd(16'h3F00, 8'hFF);
    rd(16'h4000, 8'h5A);
    u_npc_pgm.erase(`NPC_CMD_SECTION_ERASE, 16'h4001);
    u_npc_pgm.waitIdle(n);
    rd(16'h4000, 8'hFF);
    $display("t_chip done");
  endtask
  task automatic t_refuse();
    u_npc_pgm.set(1'b1, 1'b0);
    u_npc_pgm.mem(1'b1, 16'h8001, 8'h00, q, v);
    noStart();
    u_npc_pgm.set(1'b0, 1'b1);
    u_npc_pgm.mem(1'b1, 16'h8001, 8'h00, q, v);
    noStart();
    u_npc_pgm.set(1'b1, 1'b1);
    u_npc_pgm.erase(`NPC_CMD_NOP, 16'h8001);
    noStart();
    $display("t_refuse done");
  endtask
  initial
  begin
    repeat (3000) @(posedge clock);
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    t_write();
    t_chip();
    t_refuse();
    summarize();
  end
endmodule
